// >>> verilog/bbf_exec_core.sv
// Functional notes
// - Carry branches jump PC+k+1, flags untouched
// - Negative and signed branches test N, N^V
// - Half-carry branches test H, flags untouched
// - Transfer branches test T, flags untouched
// - Overflow branches test V, flags untouched
// - Interrupt branches test global enable flag
// - I/O bit force one/zero, two cycles
// - Logical shifts insert zero, update ZCNV
// - Rotates go through carry, update ZCNV
// - Arithmetic right shift keeps bit seven
// - Bit store to T, bit load from T
// - Interrupt enable sets, disable clears, one cycle
// - Flag instructions change at most one flag
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module bbf_exec_core import bbf_pkg::*; (
  input wire logic aclk, // Core clock, 20 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  // ******************************
  // Declarations
  // ******************************
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_hold_ff, w_hold_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, wdata_ff, rd_word;
  logic [3:0] wstrb_ff;
  logic [7:0] waddr_ff;
  logic rd_err, wr_do, wr_err, issue;
  logic bw_flags, bw_pc, bw_gpr, bw_io, bw_instr;
  logic [7:0] w_off, r_off;
  bbf_state_t state_ff;
  bbf_instr_t instr_ff, new_instr;
  logic [7:0] flags_ff, nxt_flags, cyc_ff, rd_val;
  logic [15:0] pc_ff, k_ext;
  logic [7:0] gpr_ff [NREG];
  logic [7:0] io_ff [NREG];
  logic taken_ff, ex_first, is_branch, is_flagop, is_shift, is_io, br_cond, new_legal;
  bbf_shres_t shres;

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ******************************
  // AXI4-Lite write channels
  // ******************************
  // Address and data are caught separately so either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      awready_ff <= 1'b0;
      waddr_ff <= REG_RST;
    end else if (s_axi_awvalid && awready_ff) begin
      aw_hold_ff <= 1'b1;
      awready_ff <= 1'b0;
      waddr_ff <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_hold_ff <= 1'b0;
    end else if (!aw_hold_ff && !bvalid_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_ff <= 1'b0;
      wready_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (s_axi_wvalid && wready_ff) begin
      w_hold_ff <= 1'b1;
      wready_ff <= 1'b0;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_do) begin
      w_hold_ff <= 1'b0;
    end else if (!w_hold_ff && !bvalid_ff) begin
      wready_ff <= 1'b1;
    end
  end

  // Response follows the cycle in which both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Write decode; address bits [1:0] are ignored
  assign wr_do = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign w_off = {waddr_ff[7:IDX_LSB], 2'h0};
  assign bw_flags = wr_do && waddr_ff[BANK_LSB +: 3] == BANK_CTL && w_off == OFS_FLAGS && wstrb_ff[0];
  assign bw_pc = wr_do && waddr_ff[BANK_LSB +: 3] == BANK_CTL && w_off == OFS_PC;
  assign bw_gpr = wr_do && waddr_ff[BANK_LSB +: 3] == BANK_GPR && wstrb_ff[0];
  assign bw_io = wr_do && waddr_ff[BANK_LSB +: 3] == BANK_IO && wstrb_ff[0];
  assign bw_instr = wr_do && waddr_ff[BANK_LSB +: 3] == BANK_CTL && w_off == OFS_INSTR;
  // A new instruction is refused while one runs, or when malformed
  assign issue = bw_instr && state_ff == ST_IDLE && new_legal && (wstrb_ff & ISSUE_STRB) == ISSUE_STRB;
  assign wr_err = !(issue || bw_pc || waddr_ff[BANK_LSB +: 3] == BANK_GPR || waddr_ff[BANK_LSB +: 3] == BANK_IO
    || (waddr_ff[BANK_LSB +: 3] == BANK_CTL && w_off == OFS_FLAGS));

  // Field extraction and legality of a written instruction word
  always_comb begin
    new_instr.op = bbf_op_t'(wdata_ff[5:0]);
    new_instr.bsel = wdata_ff[INSTR_BIT_LSB +: 3];
    new_instr.ridx = wdata_ff[INSTR_REG_LSB +: 3];
    new_instr.k = wdata_ff[INSTR_K_LSB +: 7];
    new_legal = (wdata_ff[5:4] == OPG_BRANCH) || (wdata_ff[5:4] == OPG_FLAG);
    case (bbf_op_t'(wdata_ff[5:0]))
      shift_left_logical, shift_right_logical, rotate_left_via_carry, rotate_right_via_carry,
      shift_right_arith, io_bit_force_zero, io_bit_force_one, bit_to_transfer_flag,
      transfer_flag_to_bit: new_legal = 1'b1;
      default: ;
    endcase
  end

  // ******************************
  // AXI4-Lite read channel
  // ******************************
  // Data is sampled at the address handshake, answer one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (rvalid_ff) begin
      if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else begin
      arready_ff <= 1'b1;
    end
  end

  assign r_off = {s_axi_araddr[7:IDX_LSB], 2'h0};

  // Read mux; unused upper bits read as zero
  always_comb begin
    rd_word = '0;
    rd_err = 1'b0;
    case (s_axi_araddr[BANK_LSB +: 3])
      BANK_GPR: rd_word[7:0] = gpr_ff[s_axi_araddr[IDX_LSB +: 3]];
      BANK_IO: rd_word[7:0] = io_ff[s_axi_araddr[IDX_LSB +: 3]];
      BANK_CTL: begin
        case (r_off)
          OFS_INSTR: begin
            rd_word[5:0] = instr_ff.op;
            rd_word[INSTR_BIT_LSB +: 3] = instr_ff.bsel;
            rd_word[INSTR_REG_LSB +: 3] = instr_ff.ridx;
            rd_word[INSTR_K_LSB +: 7] = instr_ff.k;
          end
          OFS_FLAGS: rd_word[7:0] = flags_ff;
          OFS_PC: rd_word[15:0] = pc_ff;
          OFS_STAT: begin
            rd_word[STAT_BUSY_BIT] = (state_ff != ST_IDLE);
            rd_word[STAT_TAKEN_BIT] = taken_ff;
            rd_word[STAT_CYC_LSB +: 8] = cyc_ff;
          end
          default: rd_err = 1'b1;
        endcase
      end
      default: rd_err = 1'b1;
    endcase
  end

  // ******************************
  // Instruction sequencing
  // ******************************
  assign ex_first = (state_ff == ST_FIRST);
  assign is_branch = (instr_ff.op[5:4] == OPG_BRANCH);
  assign is_flagop = (instr_ff.op[5:4] == OPG_FLAG);
  assign is_io = (instr_ff.op == io_bit_force_zero) || (instr_ff.op == io_bit_force_one);
  assign rd_val = gpr_ff[instr_ff.ridx];
  assign k_ext = {{9{instr_ff.k[6]}}, instr_ff.k};

  always_comb begin
    is_shift = 1'b0;
    case (instr_ff.op)
      shift_left_logical, shift_right_logical, rotate_left_via_carry, rotate_right_via_carry,
      shift_right_arith: is_shift = 1'b1;
      default: ;
    endcase
  end

  // Branch test: pick the flag term, then invert for the zero variants
  always_comb begin
    case (instr_ff.op[3:1])
      3'h0, 3'h1: br_cond = flags_ff[FLG_C];
      3'h2: br_cond = flags_ff[FLG_N];
      3'h3: br_cond = flags_ff[FLG_N] ^ flags_ff[FLG_V];
      3'h4: br_cond = flags_ff[FLG_H];
      3'h5: br_cond = flags_ff[FLG_T];
      3'h6: br_cond = flags_ff[FLG_V];
      default: br_cond = flags_ff[FLG_I];
    endcase
    br_cond = br_cond ^ instr_ff.op[0];
  end

  // Second cycle only for a taken branch or an I/O bit access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      instr_ff <= '0;
      cyc_ff <= CYC_NONE;
      taken_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (issue) begin
            instr_ff <= new_instr;
            state_ff <= ST_FIRST;
          end
        end
        ST_FIRST: begin
          taken_ff <= is_branch && br_cond;
          if ((is_branch && br_cond) || is_io) begin
            state_ff <= ST_SECOND;
          end else begin
            state_ff <= ST_IDLE;
            cyc_ff <= CYC_SHORT;
          end
        end
        ST_SECOND: begin
          state_ff <= ST_IDLE;
          cyc_ff <= CYC_LONG;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Program counter: execution wins over a bus write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_ff <= PC_RST;
    end else if (state_ff == ST_SECOND && is_branch) begin
      pc_ff <= pc_ff + k_ext + PC_STEP;
    end else if (ex_first && !(is_branch && br_cond)) begin
      pc_ff <= pc_ff + PC_STEP;
    end else if (bw_pc) begin
      if (wstrb_ff[0]) pc_ff[7:0] <= wdata_ff[7:0];
      if (wstrb_ff[1]) pc_ff[15:8] <= wdata_ff[15:8];
    end
  end

  bbf_shift_unit u_shift (
    .op(instr_ff.op),
    .din(rd_val),
    .cin(flags_ff[FLG_C]),
    .res(shres)
  );

  // Status flags: bus write first, then execution overlays its own bits
  always_comb begin
    nxt_flags = flags_ff;
    if (bw_flags) nxt_flags = wdata_ff[7:0];
    if (ex_first) begin
      if (is_flagop) begin
        nxt_flags[instr_ff.op[3:1]] = instr_ff.op[0];
      end else if (is_shift) begin
        nxt_flags[FLG_C] = shres.c;
        nxt_flags[FLG_Z] = shres.z;
        nxt_flags[FLG_N] = shres.n;
        nxt_flags[FLG_V] = shres.v;
      end else if (instr_ff.op == bit_to_transfer_flag) begin
        nxt_flags[FLG_T] = rd_val[instr_ff.bsel];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) flags_ff <= FLAGS_RST;
    else flags_ff <= nxt_flags;
  end

  // Working registers; a shift or bit load beats a bus write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NREG; i++) gpr_ff[i] <= REG_RST;
    end else if (ex_first && is_shift) begin
      gpr_ff[instr_ff.ridx] <= shres.dout;
    end else if (ex_first && instr_ff.op == transfer_flag_to_bit) begin
      gpr_ff[instr_ff.ridx][instr_ff.bsel] <= flags_ff[FLG_T];
    end else if (bw_gpr) begin
      gpr_ff[waddr_ff[IDX_LSB +: 3]] <= wdata_ff[7:0];
    end
  end

  // I/O registers; the bit is written in the second cycle of the access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NREG; i++) io_ff[i] <= REG_RST;
    end else if (state_ff == ST_SECOND && is_io) begin
      io_ff[instr_ff.ridx][instr_ff.bsel] <= instr_ff.op[0];
    end else if (bw_io) begin
      io_ff[waddr_ff[IDX_LSB +: 3]] <= wdata_ff[7:0];
    end
  end

  // ******************************
  // Assertions
  // ******************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_taken;
    ex_first && is_branch && br_cond ##1 state_ff == ST_SECOND;
  endsequence

  sequence s_io_op;
    ex_first && is_io ##1 state_ff == ST_SECOND;
  endsequence

  a_br_taken_pc: assert property (s_taken |=> pc_ff == $past(pc_ff) + k_ext + PC_STEP && cyc_ff == CYC_LONG)
    else $error("taken branch target or cycle count wrong");
  a_signed_cond: assert property (ex_first && instr_ff.op == branch_signed_ge
    |-> br_cond == !(flags_ff[FLG_N] ^ flags_ff[FLG_V]))
    else $error("signed branch test wrong");
  a_br_flags_kept: assert property (ex_first && is_branch && !bw_flags ##1 !bw_flags
    |=> flags_ff == $past(flags_ff, 2))
    else $error("branch changed a flag");
  a_transfer_cond: assert property (ex_first && instr_ff.op == branch_on_transfer_zero
    |-> br_cond == !flags_ff[FLG_T])
    else $error("transfer branch test wrong");
  a_ovf_cond: assert property (ex_first && instr_ff.op == branch_on_overflow_one
    |-> br_cond == flags_ff[FLG_V])
    else $error("overflow branch test wrong");
  a_irq_cond: assert property (ex_first && instr_ff.op == branch_if_irq_disabled
    |-> br_cond == !flags_ff[FLG_I])
    else $error("interrupt branch test wrong");
  a_io_bit_write: assert property (s_io_op
    |=> io_ff[instr_ff.ridx][instr_ff.bsel] == instr_ff.op[0] && cyc_ff == CYC_LONG)
    else $error("I/O bit not forced in two cycles");
  a_lsl_result: assert property (ex_first && instr_ff.op == shift_left_logical
    |=> gpr_ff[instr_ff.ridx] == {$past(rd_val[6:0]), 1'b0} && flags_ff[FLG_C] == $past(rd_val[7]))
    else $error("logical left shift wrong");
  a_rol_carry: assert property (ex_first && instr_ff.op == rotate_left_via_carry
    |=> gpr_ff[instr_ff.ridx] == {$past(rd_val[6:0]), $past(flags_ff[FLG_C])})
    else $error("rotate did not take old carry");
  a_asr_msb: assert property (ex_first && instr_ff.op == shift_right_arith
    |=> gpr_ff[instr_ff.ridx] == {$past(rd_val[7]), $past(rd_val[7:1])})
    else $error("arithmetic shift lost bit seven");
  a_bst_copy: assert property (ex_first && instr_ff.op == bit_to_transfer_flag
    |=> flags_ff[FLG_T] == $past(rd_val[instr_ff.bsel]))
    else $error("bit store to transfer flag wrong");
  a_irq_on: assert property (ex_first && instr_ff.op == irq_global_on
    |=> flags_ff[FLG_I] && state_ff == ST_IDLE)
    else $error("interrupt enable not set in one cycle");
  a_flag_only: assert property (ex_first && is_flagop && !bw_flags
    |=> (flags_ff ^ $past(flags_ff)) == ((flags_ff ^ $past(flags_ff)) & (8'h01 << $past(instr_ff.op[3:1]))))
    else $error("flag instruction touched another flag");
  a_br_not_taken: assert property (ex_first && is_branch && !br_cond
    |=> state_ff == ST_IDLE && cyc_ff == CYC_SHORT && pc_ff == $past(pc_ff) + PC_STEP)
    else $error("untaken branch not one cycle");
endmodule : bbf_exec_core

// >>> verilog/bbf_pkg.sv
package bbf_pkg;
  // ******************************
  // Register map and fields
  // ******************************
  localparam logic [2:0] BANK_CTL = 3'h0;
  localparam logic [2:0] BANK_GPR = 3'h1;
  localparam logic [2:0] BANK_IO = 3'h2;
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam int BANK_LSB = 5;
  localparam int IDX_LSB = 2;
  localparam int NREG = 8;
  localparam int INSTR_BIT_LSB = 8;
  localparam int INSTR_REG_LSB = 12;
  localparam int INSTR_K_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TAKEN_BIT = 1;
  localparam int STAT_CYC_LSB = 8;
  localparam logic [3:0] ISSUE_STRB = 4'h7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] CYC_NONE = 8'h00;
  localparam logic [7:0] CYC_SHORT = 8'h01;
  localparam logic [7:0] CYC_LONG = 8'h02;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Flag positions in the status byte
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam logic [1:0] OPG_BRANCH = 2'h0;
  localparam logic [1:0] OPG_FLAG = 2'h2;

  // ******************************
  // Types
  // ******************************
  // Branches: op[3:1] picks the flag test, op[0] set means test for zero.
  // Flag ops: op[3:1] is the flag position, op[0] the new value.
  typedef enum logic [5:0] {
    branch_on_carry_one = 6'h00, branch_on_carry_zero = 6'h01,
    branch_unsigned_lt = 6'h02, branch_unsigned_ge = 6'h03,
    branch_on_negative = 6'h04, branch_on_positive = 6'h05,
    branch_signed_lt = 6'h06, branch_signed_ge = 6'h07,
    branch_on_halfcarry_one = 6'h08, branch_on_halfcarry_zero = 6'h09,
    branch_on_transfer_one = 6'h0a, branch_on_transfer_zero = 6'h0b,
    branch_on_overflow_one = 6'h0c, branch_on_overflow_zero = 6'h0d,
    branch_if_irq_enabled = 6'h0e, branch_if_irq_disabled = 6'h0f,
    shift_left_logical = 6'h10, shift_right_logical = 6'h11,
    rotate_left_via_carry = 6'h12, rotate_right_via_carry = 6'h13,
    shift_right_arith = 6'h14, io_bit_force_zero = 6'h18, io_bit_force_one = 6'h19,
    bit_to_transfer_flag = 6'h1c, transfer_flag_to_bit = 6'h1d,
    carry_flag_zero = 6'h20, carry_flag_one = 6'h21, zero_flag_zero = 6'h22, zero_flag_one = 6'h23,
    negative_flag_zero = 6'h24, negative_flag_one = 6'h25,
    overflow_flag_zero = 6'h26, overflow_flag_one = 6'h27, sign_flag_zero = 6'h28, sign_flag_one = 6'h29,
    halfcarry_flag_zero = 6'h2a, halfcarry_flag_one = 6'h2b,
    transfer_flag_zero = 6'h2c, transfer_flag_one = 6'h2d, irq_global_off = 6'h2e, irq_global_on = 6'h2f
  } bbf_op_t;

  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_FIRST = 2'h1, ST_SECOND = 2'h2} bbf_state_t;

  typedef struct packed {
    logic [6:0] k;
    logic [2:0] ridx;
    logic [2:0] bsel;
    bbf_op_t op;
  } bbf_instr_t;

  typedef struct packed {
    logic [7:0] dout;
    logic c;
    logic z;
    logic n;
    logic v;
  } bbf_shres_t;
endpackage : bbf_pkg

// >>> verilog/bbf_shift_unit.sv
`timescale 1ns/1ps
module bbf_shift_unit import bbf_pkg::*; (
  input wire bbf_op_t op, // Shift or rotate kind
  input wire logic [7:0] din, // Operand byte
  input wire logic cin, // Current carry flag
  output bbf_shres_t res // Result byte and new flags
);
  logic [7:0] r;
  logic c;

  // One-place shifts; the bit pushed out always lands in carry
  always_comb begin
    r = din;
    c = cin;
    case (op)
      shift_left_logical: begin
        r = {din[6:0], 1'b0};
        c = din[7];
      end
      shift_right_logical: begin
        r = {1'b0, din[7:1]};
        c = din[0];
      end
      rotate_left_via_carry: begin
        r = {din[6:0], cin};
        c = din[7];
      end
      rotate_right_via_carry: begin
        r = {cin, din[7:1]};
        c = din[0];
      end
      shift_right_arith: begin
        r = {din[7], din[7:1]};
        c = din[0];
      end
      default: begin
        r = din;
        c = cin;
      end
    endcase
    res.dout = r;
    res.c = c;
    res.z = (r == REG_RST);
    res.n = r[7];
    res.v = r[7] ^ c; // Overflow is negative xor carry after any shift
  end
endmodule : bbf_shift_unit

// >>> verification/bbf_exec_core_tb.sv
`timescale 1ns/1ps
module testbench import bbf_pkg::*; ;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int bad_count = 0;
  int samples_checked = 0;

  // ******************************
  // Clock and device
  // ******************************
  always #25 aclk = ~aclk;

  bbf_exec_core dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ******************************
  // Bus tasks and compares
  // ******************************
  task automatic finish_test();
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s resp %h exp %h", $time, what, got, exp);
    end
  endtask : chk_resp

  // A wait that runs out counts once and ends the run
  task automatic hang(input int n);
    if (n >= 100) begin
      bad_count++;
      $display("[ERR] %0t bus timeout", $time);
      finish_test();
    end
  endtask : hang

  // Extra edge at the end keeps a strobe from being set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    hang(n);
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    hang(n);
    @(posedge aclk);
  endtask : rd

  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hf, r);
    chk_resp(r, RESP_OKAY, "write");
  endtask : put

  task automatic get(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk_resp(r, RESP_OKAY, what);
    chk(d, exp, what);
  endtask : get

  // Status reserved bits are not judged, only busy, taken and cycle count
  task automatic stat(input logic [7:0] cyc, input logic tk);
    logic [31:0] d;
    logic [1:0] r;
    rd(OFS_STAT, d, r);
    chk(d & 32'h0000ff03, {16'h0, cyc, 6'h0, tk, 1'b0}, "status");
  endtask : stat

  task automatic exec(input logic [5:0] op, input logic [2:0] b, input logic [2:0] ri, input logic [6:0] k);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    put(OFS_INSTR, {9'h0, k, 1'b0, ri, 1'b0, b, 2'h0, op});
    for (n = 0; n < 100; n++) begin
      rd(OFS_STAT, d, r);
      if (d[STAT_BUSY_BIT] === 1'b0) break;
    end
    hang(n);
  endtask : exec

  function automatic logic [8:0] shx(input logic [5:0] op, input logic [7:0] d, input logic c);
    logic [7:0] q;
    logic co;
    case (op)
      6'h10: {co, q} = {d, 1'b0};
      6'h11: {q, co} = {1'b0, d};
      6'h12: {co, q} = {d, c};
      6'h13: {q, co} = {c, d};
      default: {q, co} = {d[7], d};
    endcase
    return {q, co};
  endfunction : shx

  // ******************************
  // Main sequence
  // ******************************
  initial begin
    static logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h28, 8'hc5};
    static logic [6:0] ks [4] = '{7'h7e, 7'h05, 7'h40, 7'h3f};
    logic [7:0] f, e, dv;
    logic [8:0] sr;
    logic [31:0] d;
    logic [1:0] r;
    logic c, tk;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    get(OFS_FLAGS, 32'h0, "flags reset");
    get(OFS_PC, 32'h0, "pc reset");
    stat(CYC_NONE, 1'b0);
    // Every branch kind against several flag patterns and offsets
    for (int p = 0; p < 4; p++) begin
      for (int o = 0; o < 16; o++) begin
        f = pats[p];
        put(OFS_FLAGS, {24'h0, f});
        put(OFS_PC, 32'h100);
        case (o >> 1)
          0, 1: c = f[FLG_C];
          2: c = f[FLG_N];
          3: c = f[FLG_N] ^ f[FLG_V];
          4: c = f[FLG_H];
          5: c = f[FLG_T];
          6: c = f[FLG_V];
          default: c = f[FLG_I];
        endcase
        tk = c ^ o[0];
        exec(o[5:0], 3'h0, 3'h0, ks[p]);
        get(OFS_PC, tk ? 32'h101 + {{25{ks[p][6]}}, ks[p]} : 32'h101, "pc");
        get(OFS_FLAGS, {24'h0, f}, "branch flags");
        stat(tk ? CYC_LONG : CYC_SHORT, tk);
      end
    end
    // Shifts and rotates, carry in both ways, zero result included
    for (int o = 16; o < 21; o++) begin
      for (int ci = 0; ci < 2; ci++) begin
        f = 8'h50 | ci[7:0];
        dv = ci ? 8'h01 : 8'h96;
        sr = shx(o[5:0], dv, ci[0]);
        e = {f[7:4], sr[8] ^ sr[0], sr[8], sr[8:1] == 8'h00, sr[0]};
        put(OFS_FLAGS, {24'h0, f});
        put({BANK_GPR, 3'h1, 2'h0}, {24'h0, dv});
        exec(o[5:0], 3'h0, 3'h1, 7'h00);
        get({BANK_GPR, 3'h1, 2'h0}, {24'h0, sr[8:1]}, "shift data");
        get(OFS_FLAGS, {24'h0, e}, "shift flags");
        stat(CYC_SHORT, 1'b0);
      end
    end
    // I/O bit force one then zero, flags untouched
    put(OFS_FLAGS, 32'h3c);
    put({BANK_IO, 3'h3, 2'h0}, 32'h5a);
    exec(6'h19, 3'h0, 3'h3, 7'h00);
    get({BANK_IO, 3'h3, 2'h0}, 32'h5b, "io one");
    stat(CYC_LONG, 1'b0);
    exec(6'h18, 3'h6, 3'h3, 7'h00);
    get({BANK_IO, 3'h3, 2'h0}, 32'h1b, "io zero");
    get(OFS_FLAGS, 32'h3c, "io flags");
    // Bit store into T, then T back into another register
    put(OFS_FLAGS, 32'h0);
    put({BANK_GPR, 3'h2, 2'h0}, 32'h80);
    put({BANK_GPR, 3'h4, 2'h0}, 32'h11);
    exec(6'h1c, 3'h7, 3'h2, 7'h00);
    get(OFS_FLAGS, 32'h40, "bit store");
    exec(6'h1d, 3'h3, 3'h4, 7'h00);
    get({BANK_GPR, 3'h4, 2'h0}, 32'h19, "bit load");
    get(OFS_FLAGS, 32'h40, "load flags");
    stat(CYC_SHORT, 1'b0);
    // Each single flag set and clear from a mixed pattern
    for (int o = 32; o < 48; o++) begin
      e = 8'h55;
      e[o[3:1]] = o[0];
      put(OFS_FLAGS, 32'h55);
      exec(o[5:0], 3'h0, 3'h0, 7'h00);
      get(OFS_FLAGS, {24'h0, e}, "flag op");
      stat(CYC_SHORT, 1'b0);
    end
    // Refused accesses
    wr(OFS_INSTR, 32'h15, 4'hf, r);
    chk_resp(r, RESP_SLVERR, "illegal op");
    wr(OFS_INSTR, 32'h21, 4'h3, r);
    chk_resp(r, RESP_SLVERR, "part strobe");
    wr(OFS_STAT, 32'h0, 4'hf, r);
    chk_resp(r, RESP_SLVERR, "status write");
    rd(8'h80, d, r);
    chk_resp(r, RESP_SLVERR, "unmapped");
    chk(d, 32'h0, "unmapped data");
    // The last flag op turned the interrupt enable on; refused writes must leave that alone
    get(OFS_FLAGS, 32'hd5, "refused flags");
    finish_test();
  end
endmodule : testbench
